// ### xmem_pkg.sv
// Notes on behaviour
// - Port bank select 0 puts pins on lower four ports, 1 on upper four.
// - Pins are claimed only during an off-chip external move, then released.
// - Drivers of pins acting as inputs, such as read data, are disabled.
// - Open-drain or push-pull pin output mode is never touched here.
// - For 8-bit moves the page register gives the upper address byte, except in memory mode 11 and off-chip in mode 01.
// - Mux mode select 0 shares address/data pins; 1 uses separate pins.
// - Memory mode 00 sends every move on-chip, wrapping modulo 8k.
// - Internal mode: 8-bit moves use page plus R0/R1; 16-bit use data pointer.
// - Split modes send addresses below 8k on-chip, above it off-chip.
// - Split without bank select: 8-bit off-chip leaves A[15:8] undriven.
// - Split without bank select: page register decides on/off-chip for 8-bit moves.
// - Split mode 16-bit moves route by data pointer and drive all 16 lines.
// - Memory mode 10: 8-bit off-chip moves take upper byte from page.
// - Memory mode 11 sends every move off-chip; on-chip RAM invisible.
// - Latch pulse width code 0..3 gives ALE high and low of 1..4 cycles.
// - Mux mode: low address on AD while ALE high, data afterwards with strobe.
// - Non-mux mode puts address and data on separate pins.
// - External-only 8-bit moves ignore page, leave upper lines undriven.
// - Split with bank select 8-bit off-chip moves drive all 16 lines.
package xmem_pkg;
  localparam logic [7:0] PAGE_IDX = 8'hA2;
  localparam logic [7:0] CONFIG_IDX = 8'hA3;
  localparam logic [7:0] STATUS_IDX = 8'hA4;
  localparam logic [11:0] PAGE_ADDR = {2'b00, PAGE_IDX, 2'b00};
  localparam logic [11:0] CONFIG_ADDR = {2'b00, CONFIG_IDX, 2'b00};
  localparam logic [11:0] STATUS_ADDR = {2'b00, STATUS_IDX, 2'b00};
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [5:0] CONFIG_RESET = 6'h03;
  localparam int CFG_BANK_BIT = 5;
  localparam int CFG_NONMUX_BIT = 4;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_ALE_LSB = 0;
  localparam logic [1:0] MODE_INTERNAL = 2'h0;
  localparam logic [1:0] MODE_SPLIT_NOBANK = 2'h1;
  localparam logic [1:0] MODE_SPLIT_BANK = 2'h2;
  localparam logic [1:0] MODE_EXTERNAL = 2'h3;
  localparam logic [2:0] ONCHIP_TOP = 3'h0;
  localparam int PIN_WR = 7;
  localparam int PIN_RD = 6;
  localparam int PIN_ALE = 5;
  localparam int LOWADDR_LSB = 8;
  localparam int HIGHADDR_LSB = 16;
  localparam int DATA_LSB = 24;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ONCHIP = 3'b001,
    ST_ONRESP = 3'b010,
    ST_ALEHI = 3'b011,
    ST_ALELO = 3'b100,
    ST_SETUP = 3'b101,
    ST_STROBE = 3'b110,
    ST_HOLD = 3'b111
  } state_t;
endpackage : xmem_pkg

// ### external_data_memory_interface.sv
module external_data_memory_interface
  import xmem_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  // AXI4-Lite register slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // CPU external move request
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic reqWide,
  input wire logic [15:0] reqDataPointer,
  input wire logic [7:0] reqRegLow,
  input wire logic [7:0] reqWdata,
  output logic rspValid,
  output logic [7:0] rspRdata,
  // Transaction timing
  input wire logic [1:0] setupCycles,
  input wire logic [3:0] strobeCode,
  input wire logic [1:0] holdCycles,
  // On-chip data RAM
  output logic ramEn,
  output logic ramWe,
  output logic [12:0] ramAddr,
  output logic [7:0] ramWdata,
  input wire logic [7:0] ramRdata,
  // Lower and upper port banks, four ports each
  input wire logic [31:0] loPortIn,
  output logic [31:0] loPortOut,
  output logic [31:0] loPortOe,
  output logic [31:0] loPortClaim,
  input wire logic [31:0] hiPortIn,
  output logic [31:0] hiPortOut,
  output logic [31:0] hiPortOe,
  output logic [31:0] hiPortClaim
);

  typedef struct packed {
    state_t st;
    logic [3:0] cnt;
    logic [7:0] page;
    logic [5:0] cfg;
    logic write;
    logic wide;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rspValid;
    logic lastOnChip;
    logic awHeld;
    logic [11:0] awAddr;
    logic wHeld;
    logic [7:0] wData;
    logic wLane0;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } regs_t;

  localparam regs_t REGS_RESET = '{
    st: ST_IDLE, cnt: 4'h0, page: PAGE_RESET, cfg: CONFIG_RESET, write: 1'b0,
    wide: 1'b0, addr: 16'h0000, wdata: 8'h00, rdata: 8'h00, rspValid: 1'b0,
    lastOnChip: 1'b0, awHeld: 1'b0, awAddr: 12'h000, wHeld: 1'b0, wData: 8'h00,
    wLane0: 1'b0, bValid: 1'b0, bResp: RESP_OKAY, rValid: 1'b0, rData: 32'h00000000,
    rResp: RESP_OKAY
  };

  regs_t s_q;
  regs_t s_d;

  logic [1:0] memMode;
  logic nonMux;
  logic bankHigh;
  logic [1:0] aleCode;
  logic [15:0] reqAddr;
  logic reqOnChip;
  logic offChip;
  logic driveUpper;
  logic [31:0] busOut;
  logic [31:0] busOe;
  logic [31:0] busClaim;
  logic [7:0] dataIn;

  assign memMode = s_q.cfg[CFG_MODE_LSB +: 2];
  assign nonMux = s_q.cfg[CFG_NONMUX_BIT];
  assign bankHigh = s_q.cfg[CFG_BANK_BIT];
  assign aleCode = s_q.cfg[CFG_ALE_LSB +: 2];

  // Effective address: data pointer, or page byte over R0/R1
  assign reqAddr = reqWide ? reqDataPointer : {s_q.page, reqRegLow};

  always_comb begin
    case (memMode)
      MODE_INTERNAL: reqOnChip = 1'b1;
      MODE_EXTERNAL: reqOnChip = 1'b0;
      default: reqOnChip = (reqAddr[15:13] == ONCHIP_TOP);
    endcase
  end

  assign reqReady = (s_q.st == ST_IDLE);
  assign rspValid = s_q.rspValid;
  assign rspRdata = s_q.rdata;

  assign ramEn = (s_q.st == ST_ONCHIP);
  assign ramWe = (s_q.st == ST_ONCHIP) && s_q.write;
  assign ramAddr = s_q.addr[12:0];
  assign ramWdata = s_q.wdata;

  assign offChip = (s_q.st == ST_ALEHI) || (s_q.st == ST_ALELO) || (s_q.st == ST_SETUP)
    || (s_q.st == ST_STROBE) || (s_q.st == ST_HOLD);

  // Upper lines left to port latches for narrow moves except bank select
  assign driveUpper = s_q.wide || (memMode == MODE_SPLIT_BANK);

  assign dataIn = bankHigh ? hiPortIn[DATA_LSB +: 8] : loPortIn[DATA_LSB +: 8];

  always_comb begin
    busOut = 32'hFFFFFFFF;
    busOe = 32'h00000000;
    busClaim = 32'h00000000;
    if (offChip) begin
      busOut[PIN_WR] = !((s_q.st == ST_STROBE) && s_q.write);
      busOut[PIN_RD] = !((s_q.st == ST_STROBE) && !s_q.write);
      busOe[PIN_WR] = 1'b1;
      busOe[PIN_RD] = 1'b1;
      busClaim[PIN_WR] = 1'b1;
      busClaim[PIN_RD] = 1'b1;
      if (driveUpper) begin
        busOut[HIGHADDR_LSB +: 8] = s_q.addr[15:8];
        busOe[HIGHADDR_LSB +: 8] = 8'hFF;
        busClaim[HIGHADDR_LSB +: 8] = 8'hFF;
      end
      busClaim[DATA_LSB +: 8] = 8'hFF;
      if (nonMux) begin
        busOut[LOWADDR_LSB +: 8] = s_q.addr[7:0];
        busOe[LOWADDR_LSB +: 8] = 8'hFF;
        busClaim[LOWADDR_LSB +: 8] = 8'hFF;
        busOut[DATA_LSB +: 8] = s_q.wdata;
        busOe[DATA_LSB +: 8] = {8{s_q.write}};
      end else begin
        busOut[PIN_ALE] = (s_q.st == ST_ALEHI);
        busOe[PIN_ALE] = 1'b1;
        busClaim[PIN_ALE] = 1'b1;
        if (s_q.st == ST_ALEHI) begin
          busOut[DATA_LSB +: 8] = s_q.addr[7:0];
          busOe[DATA_LSB +: 8] = 8'hFF;
        end else begin
          busOut[DATA_LSB +: 8] = s_q.wdata;
          busOe[DATA_LSB +: 8] = {8{s_q.write}};
        end
      end
    end
  end

  // Bank routing; output mode of each pin stays with the port logic
  assign loPortOut = busOut;
  assign hiPortOut = busOut;
  assign loPortOe = bankHigh ? 32'h00000000 : busOe;
  assign loPortClaim = bankHigh ? 32'h00000000 : busClaim;
  assign hiPortOe = bankHigh ? busOe : 32'h00000000;
  assign hiPortClaim = bankHigh ? busClaim : 32'h00000000;

  assign s_axi_awready = !s_q.awHeld && !s_q.bValid;
  assign s_axi_wready = !s_q.wHeld && !s_q.bValid;
  assign s_axi_bvalid = s_q.bValid;
  assign s_axi_bresp = s_q.bResp;
  assign s_axi_arready = !s_q.rValid;
  assign s_axi_rvalid = s_q.rValid;
  assign s_axi_rdata = s_q.rData;
  assign s_axi_rresp = s_q.rResp;

  always_comb begin
    s_d = s_q;
    s_d.rspValid = 1'b0;

    // Transaction sequencer
    case (s_q.st)
      ST_IDLE: begin
        if (reqValid) begin
          s_d.write = reqWrite;
          s_d.wide = reqWide;
          s_d.addr = reqAddr;
          s_d.wdata = reqWdata;
          s_d.lastOnChip = reqOnChip;
          if (reqOnChip) begin
            s_d.st = ST_ONCHIP;
          end else if (!nonMux) begin
            s_d.st = ST_ALEHI;
            s_d.cnt = {2'b00, aleCode};
          end else if (setupCycles != 2'h0) begin
            s_d.st = ST_SETUP;
            s_d.cnt = {2'b00, setupCycles - 2'h1};
          end else begin
            s_d.st = ST_STROBE;
            s_d.cnt = strobeCode;
          end
        end
      end
      ST_ONCHIP: begin
        s_d.st = ST_ONRESP;
      end
      ST_ONRESP: begin
        if (!s_q.write) begin
          s_d.rdata = ramRdata;
        end
        s_d.rspValid = 1'b1;
        s_d.st = ST_IDLE;
      end
      ST_ALEHI: begin
        if (s_q.cnt == 4'h0) begin
          s_d.st = ST_ALELO;
          s_d.cnt = {2'b00, aleCode};
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      ST_ALELO: begin
        if (s_q.cnt != 4'h0) begin
          s_d.cnt = s_q.cnt - 4'h1;
        end else if (setupCycles != 2'h0) begin
          s_d.st = ST_SETUP;
          s_d.cnt = {2'b00, setupCycles - 2'h1};
        end else begin
          s_d.st = ST_STROBE;
          s_d.cnt = strobeCode;
        end
      end
      ST_SETUP: begin
        if (s_q.cnt == 4'h0) begin
          s_d.st = ST_STROBE;
          s_d.cnt = strobeCode;
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      ST_STROBE: begin
        if (s_q.cnt != 4'h0) begin
          s_d.cnt = s_q.cnt - 4'h1;
        end else begin
          if (!s_q.write) begin
            s_d.rdata = dataIn;
          end
          if (holdCycles != 2'h0) begin
            s_d.st = ST_HOLD;
            s_d.cnt = {2'b00, holdCycles - 2'h1};
          end else begin
            s_d.st = ST_IDLE;
            s_d.rspValid = 1'b1;
          end
        end
      end
      ST_HOLD: begin
        if (s_q.cnt == 4'h0) begin
          s_d.st = ST_IDLE;
          s_d.rspValid = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase

    // Register write channel
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.awHeld = 1'b1;
      s_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.wHeld = 1'b1;
      s_d.wData = s_axi_wdata[7:0];
      s_d.wLane0 = s_axi_wstrb[0];
    end
    if (s_q.awHeld && s_q.wHeld) begin
      s_d.awHeld = 1'b0;
      s_d.wHeld = 1'b0;
      s_d.bValid = 1'b1;
      s_d.bResp = RESP_OKAY;
      case (s_q.awAddr[11:2])
        PAGE_ADDR[11:2]: begin
          if (s_q.wLane0) begin
            s_d.page = s_q.wData;
          end
        end
        CONFIG_ADDR[11:2]: begin
          if (s_q.wLane0) begin
            s_d.cfg = s_q.wData[5:0];
          end
        end
        STATUS_ADDR[11:2]: begin
          s_d.bResp = RESP_OKAY;
        end
        default: begin
          s_d.bResp = RESP_SLVERR;
        end
      endcase
    end
    if (s_q.bValid && s_axi_bready) begin
      s_d.bValid = 1'b0;
    end

    // Register read channel
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rValid = 1'b1;
      s_d.rResp = RESP_OKAY;
      case (s_axi_araddr[11:2])
        PAGE_ADDR[11:2]: s_d.rData = {24'h000000, s_q.page};
        CONFIG_ADDR[11:2]: s_d.rData = {26'h0000000, s_q.cfg};
        STATUS_ADDR[11:2]: s_d.rData = {24'h000000, 1'b0, s_q.lastOnChip, offChip,
          !reqReady, 1'b0, s_q.st};
        default: begin
          s_d.rData = 32'h00000000;
          s_d.rResp = RESP_SLVERR;
        end
      endcase
    end else if (s_q.rValid && s_axi_rready) begin
      s_d.rValid = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= REGS_RESET;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : external_data_memory_interface

// ### xmem_checker_sva.sv
module xmem_checker
  import xmem_pkg::*;
(
  input logic core_clk,
  input logic nrst,
  input logic reqValid,
  input logic reqReady,
  input logic rspValid,
  input logic ramEn,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic [31:0] loPortOut,
  input logic [31:0] loPortOe,
  input logic [31:0] loPortClaim,
  input logic [31:0] hiPortOut,
  input logic [31:0] hiPortOe,
  input logic [31:0] hiPortClaim
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [31:0] bOut, bOe, bClaim;
  logic ale, rdLow, wrLow;
  // Pins of whichever bank is claimed
  assign bClaim = loPortClaim | hiPortClaim;
  assign bOut = (|loPortClaim) ? loPortOut : hiPortOut;
  assign bOe = (|loPortClaim) ? loPortOe : hiPortOe;
  assign ale = bClaim[PIN_ALE] && bOe[PIN_ALE] && bOut[PIN_ALE];
  assign rdLow = bClaim[PIN_RD] && bOe[PIN_RD] && !bOut[PIN_RD];
  assign wrLow = bClaim[PIN_WR] && bOe[PIN_WR] && !bOut[PIN_WR];
  sequence onchipDone;
    ##2 rspValid;
  endsequence
  one_bank_a: assert property (|loPortClaim |-> hiPortClaim == 32'h0)
    else $error("both port banks claimed");
  idle_release_a: assert property (reqReady |-> bClaim == 32'h0)
    else $error("pins claimed while idle");
  oe_claim_a: assert property ((bOe & ~bClaim) == 32'h0)
    else $error("pin driven without claim");
  read_float_a: assert property (rdLow |-> bOe[31:24] == 8'h00)
    else $error("data driven during read strobe");
  onchip_time_a: assert property (ramEn |-> onchipDone)
    else $error("on-chip move answer late");
  onchip_quiet_a: assert property (ramEn |-> bClaim == 32'h0)
    else $error("pins claimed for on-chip move");
  ale_addr_a: assert property (ale |-> bOe[31:24] == 8'hFF && !rdLow && !wrLow)
    else $error("shared pins not driven with address");
  ale_fall_a: assert property ($fell(ale) |-> !rdLow && !wrLow)
    else $error("strobe at latch enable fall");
  strobe_excl_a: assert property (!(rdLow && wrLow))
    else $error("both strobes active");
  take_busy_a: assert property (reqValid && reqReady |=> !reqReady)
    else $error("move not taken");
  ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule : xmem_checker

bind external_data_memory_interface xmem_checker u_chk (.*);

// ### ext_mem_model.sv
module ext_mem_model
  import xmem_pkg::*;
#(
  parameter logic [31:0] PARK = 32'hFF5AFFFF
)
(
  input logic core_clk,
  input logic [31:0] portOut,
  input logic [31:0] portOe,
  input logic [31:0] portClaim,
  output logic [31:0] portIn,
  output logic [15:0] lastAddr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [65536];
  logic [31:0] pin;
  logic [7:0] latchQ = 8'h00;
  logic [7:0] lastD = 8'h00;
  logic [15:0] addr;
  logic rd;
  // Undriven pins show the parked port latch value
  assign pin = (portOut & portOe & portClaim) | (PARK & ~(portOe & portClaim));
  assign rd = portClaim[PIN_RD] && !pin[PIN_RD];
  assign addr = {pin[23:16], (|portOe[15:8]) ? pin[15:8] : latchQ};
  assign portIn = {rd ? mem[addr] : ~lastD, pin[23:0]};
  always @(posedge core_clk) begin
    if (pin[PIN_ALE] && portClaim[PIN_ALE]) latchQ <= pin[31:24];
    if (rd) begin
      lastD <= mem[addr];
      lastAddr <= addr;
    end
    if (portClaim[PIN_WR] && !pin[PIN_WR]) begin
      mem[addr] <= pin[31:24];
      lastAddr <= addr;
    end
  end
endmodule : ext_mem_model

// ### tb_external_data_memory_interface.sv
module tb_external_data_memory_interface
  import xmem_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, g) begin numChecks++; if ((g) !== (e)) begin errors++; \
    $display("unexpected %s expected %h seen %h", n, e, g); end end
  logic core_clk = 0;
  logic nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, loPortIn, loPortOut, loPortOe, loPortClaim;
  logic [31:0] hiPortIn, hiPortOut, hiPortOe, hiPortClaim, d;
  logic [3:0] s_axi_wstrb, strobeCode;
  logic [1:0] s_axi_bresp, s_axi_rresp, setupCycles, holdCycles, r, br;
  logic reqValid, reqReady, reqWrite, reqWide, rspValid, ramEn, ramWe;
  logic [15:0] reqDataPointer, loLast, hiLast;
  logic [7:0] reqRegLow, reqWdata, rspRdata, ramWdata, ramRdata, b;
  logic [12:0] ramAddr;
  logic [7:0] ram [8192];
  int errors = 0, numChecks = 0, cyc = 0, l;

  external_data_memory_interface dut (.*);
  ext_mem_model loMem (.core_clk(core_clk), .portOut(loPortOut), .portOe(loPortOe),
    .portClaim(loPortClaim), .portIn(loPortIn), .lastAddr(loLast));
  ext_mem_model hiMem (.core_clk(core_clk), .portOut(hiPortOut), .portOe(hiPortOe),
    .portClaim(hiPortClaim), .portIn(hiPortIn), .lastAddr(hiLast));

  always #5 core_clk = ~core_clk;
  // On-chip data RAM, one cycle read
  always @(posedge core_clk) begin
    if (ramEn && ramWe) ram[ramAddr] <= ramWdata;
    if (ramEn) ramRdata <= ram[ramAddr];
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      test_done();
    end
  end

  task automatic test_done();
    if (errors == 0 && numChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic pa, pw, pb, ga, gw, gb;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    pa = 1;
    pw = 1;
    pb = 1;
    while (pb) begin
      @(negedge core_clk);
      ga = pa && s_axi_awready;
      gw = pw && s_axi_wready;
      gb = s_axi_bvalid;
      if (gb) br = s_axi_bresp;
      @(posedge core_clk);
      if (ga) s_axi_awvalid <= 1'b0;
      if (ga) pa = 0;
      if (gw) s_axi_wvalid <= 1'b0;
      if (gw) pw = 0;
      if (gb) s_axi_bready <= 1'b0;
      if (gb) pb = 0;
    end
    // Let an edge pass so a following call never re-raises bready in this step
    @(posedge core_clk);
  endtask : wr

  task automatic rdReg(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge core_clk); while (s_axi_arready !== 1'b1);
    @(posedge core_clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge core_clk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    @(posedge core_clk);
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask : rdReg

  task automatic mv(input logic w, wd, input logic [15:0] dp, input logic [7:0] lo, wv);
    reqValid <= 1'b1;
    reqWrite <= w;
    reqWide <= wd;
    reqDataPointer <= dp;
    reqRegLow <= lo;
    reqWdata <= wv;
    do @(negedge core_clk); while (reqReady !== 1'b1);
    @(posedge core_clk);
    reqValid <= 1'b0;
    l = 0;
    do begin
      @(negedge core_clk);
      l++;
    end while (rspValid !== 1'b1);
    b = rspRdata;
    @(posedge core_clk);
  endtask : mv

  initial begin
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {reqValid, reqWrite, reqWide, reqDataPointer, reqRegLow, reqWdata, ramRdata} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, setupCycles, strobeCode, holdCycles} = '0;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rdReg(PAGE_ADDR, d, r);
    `CHK("page", 32'h00, d)
    rdReg(CONFIG_ADDR, d, r);
    `CHK("config", 32'h03, d)
    wr(CONFIG_ADDR, 32'hFFFFFFFF);
    `CHK("bresp", RESP_OKAY, br)
    rdReg(CONFIG_ADDR, d, r);
    `CHK("config", 32'h3F, d)
    rdReg(12'h000, d, r);
    `CHK("rresp", RESP_SLVERR, r)
    wr(12'h000, 32'h0);
    `CHK("bresp", RESP_SLVERR, br)
    wr(CONFIG_ADDR, 32'h10);
    wr(PAGE_ADDR, 32'h35);
    mv(1, 0, 16'h0, 8'h12, 8'hA1);
    `CHK("ram", 8'hA1, ram[13'h1512])
    mv(0, 1, 16'hF512, 8'h0, 8'h0);
    `CHK("rdata", 8'hA1, b)
    `CHK("latency", 3, l)
    wr(CONFIG_ADDR, 32'h1C);
    mv(1, 1, 16'h1234, 8'h0, 8'h5C);
    `CHK("addr", 16'h1234, loLast)
    `CHK("latency", 2, l)
    mv(0, 1, 16'h1234, 8'h0, 8'h0);
    `CHK("rdata", 8'h5C, b)
    mv(1, 0, 16'h0, 8'h34, 8'h6D);
    `CHK("addr", 16'h5A34, loLast)
    wr(CONFIG_ADDR, 32'h14);
    mv(1, 0, 16'h0, 8'h77, 8'h11);
    `CHK("addr", 16'h5A77, loLast)
    wr(PAGE_ADDR, 32'h10);
    mv(1, 0, 16'h0, 8'h77, 8'h22);
    `CHK("ram", 8'h22, ram[13'h1077])
    mv(0, 1, 16'h5A77, 8'h0, 8'h0);
    `CHK("rdata", 8'h11, b)
    for (int i = 0; i < 4; i++) begin
      wr(CONFIG_ADDR, 32'h28 | i);
      wr(PAGE_ADDR, 32'h40 + i);
      setupCycles <= 2'(i);
      strobeCode <= 4'(i);
      holdCycles <= 2'(3 - i);
      mv(1, 0, 16'h0, 8'h66, 8'h90 + 8'(i));
      `CHK("addr", {8'h40 + 8'(i), 8'h66}, hiLast)
      `CHK("latency", 7 + 3 * i, l)
      mv(0, 0, 16'h0, 8'h66, 8'h0);
      `CHK("rdata", 8'h90 + 8'(i), b)
    end
    mv(1, 1, 16'h0100, 8'h0, 8'h3C);
    `CHK("ram", 8'h3C, ram[13'h0100])
    rdReg(STATUS_ADDR, d, r);
    `CHK("status", 32'h40, d)
    test_done();
  end
endmodule : tb_external_data_memory_interface
